// ---- logic/ogp_pkg.sv ----
/*
 * ogp_pkg: shared constants for the oring switch gate and power-good block.
 * Register offsets, field positions, reset values and flag positions.
 * Assumes nothing about its surroundings beyond a SystemVerilog tool.
 */
`default_nettype none
package ogp_pkg;
    // register offsets on the register port
    localparam logic [7:0] OGP_OFS_PG_GATE_CFG = 8'h2D;
    localparam logic [7:0] OGP_OFS_SW_THR_CFG  = 8'h30;
    localparam logic [7:0] OGP_OFS_GATE_DIS    = 8'h5D;
    localparam logic [7:0] OGP_OFS_PG1_MASK    = 8'h7B;
    localparam logic [7:0] OGP_OFS_PG2_MASK    = 8'h7C;
    localparam logic [7:0] OGP_OFS_STATUS      = 8'hE0;

    // reset values
    localparam logic [7:0] OGP_RST_PG_GATE_CFG = 8'h02;
    localparam logic [7:0] OGP_RST_SW_THR_CFG  = 8'h00;
    localparam logic [7:0] OGP_RST_GATE_DIS    = 8'h00;
    localparam logic [7:0] OGP_RST_PG_MASK     = 8'hFF;
    localparam logic [7:0] OGP_RD_UNMAPPED     = 8'h00;

    // field positions
    localparam int OGP_BIT_GATE_POL    = 1;  // power_good_and_gate_config
    localparam int OGP_BIT_PG2_ALWAYS  = 3;
    localparam int OGP_THR_EN_LSB      = 5;  // switch_threshold_config
    localparam int OGP_THR_EN_W        = 2;
    localparam int OGP_THR_REV_LSB     = 2;
    localparam int OGP_THR_REV_W       = 3;
    localparam int OGP_BIT_REV_DIS     = 0;
    localparam int OGP_BIT_GATE_DIS    = 0;  // gate_disable_control

    // status register bits
    localparam int OGP_ST_GATE    = 0;
    localparam int OGP_ST_REMOTE  = 1;
    localparam int OGP_ST_FAULT   = 2;
    localparam int OGP_ST_REV     = 3;
    localparam int OGP_ST_PG1_BAD = 4;
    localparam int OGP_ST_PG2_BAD = 5;

    // masked power-good flags, positions inside the mask registers
    localparam int OGP_PG_NFLAGS   = 8;
    localparam int OGP_PGF_GATE    = 0;  // gate not active, made in-block
    localparam int OGP_PGF_SS      = 7;  // soft start
    // additional second power-good flags
    localparam int OGP_XF_NFLAGS   = 5;
    localparam int OGP_XF_SW_DIS   = 1;  // switch disable, made in-block

    // enable threshold codes: 0 %, -0.5 %, -1 %, -2 % of nominal
    typedef enum logic [1:0] {
        OGP_THR_ZERO,
        OGP_THR_HALF,
        OGP_THR_ONE,
        OGP_THR_TWO
    } ogp_thr_type;
    localparam int OGP_DIV_HALF = 200;
    localparam int OGP_DIV_ONE  = 100;
    localparam int OGP_DIV_TWO  = 50;
endpackage
`default_nettype wire

// ---- logic/ogp_gate_ctrl.sv ----
/*
 * ogp_gate_ctrl: combinational decision for the oring switch gate.
 * Assumes calibrated sense codes and a nominal output code, all unsigned,
 * and fault actions already decoded into one turn-off bit per flag.
 */
`default_nettype none
module ogp_gate_ctrl
    import ogp_pkg::*;
#(
    parameter int VW = 12,
    parameter int NF = 8
) (
    input  wire logic [VW-1:0]          local_sense_voltage_i,
    input  wire logic [VW-1:0]          bus_sense_voltage_i,
    input  wire logic [VW-1:0]          nominal_voltage_i,
    input  wire logic [NF-1:0]          fault_flag_i,
    input  wire logic [NF-1:0]          fault_act_off_i,
    input  wire logic [OGP_THR_REV_W-1:0] rev_level_i,
    input  wire logic [7:0]             thr_cfg_i,
    input  wire logic                   gate_dis_i,
    output logic                        thr_met_o,
    output logic                        fault_off_o,
    output logic                        rev_off_o,
    output logic                        gate_act_o,
    output logic                        remote_sel_o
);
    // fraction of nominal, negated later; decode used for the one field
    function automatic logic [VW:0] thr_mag(input logic [1:0] code,
                                           input logic [VW-1:0] nom);
        logic [VW:0] n;
        n = {1'b0, nom};
        case (ogp_thr_type'(code))
            OGP_THR_ZERO: thr_mag = '0;
            OGP_THR_HALF: thr_mag = (VW+1)'(n / OGP_DIV_HALF);
            OGP_THR_ONE:  thr_mag = (VW+1)'(n / OGP_DIV_ONE);
            OGP_THR_TWO:  thr_mag = (VW+1)'(n / OGP_DIV_TWO);
            default:      thr_mag = '0;
        endcase
    endfunction

    wire logic signed [VW+1:0] drop_w;
    wire logic signed [VW+1:0] limit_w;
    wire logic [1:0]           en_code_w;
    wire logic [OGP_THR_REV_W-1:0] rev_thr_w;

    // forward drop local minus bus, compared to minus the fraction
    assign en_code_w = thr_cfg_i[OGP_THR_EN_LSB +: OGP_THR_EN_W];
    assign drop_w  = $signed({2'b00, local_sense_voltage_i})
                   - $signed({2'b00, bus_sense_voltage_i});
    assign limit_w = -$signed({1'b0, thr_mag(en_code_w, nominal_voltage_i)});
    assign thr_met_o = (drop_w > limit_w);

    // any flag set with a turn-off action holds the switch off
    assign fault_off_o = |(fault_flag_i & fault_act_off_i);

    // reverse-current comparator, ignored when disabled
    assign rev_thr_w = thr_cfg_i[OGP_THR_REV_LSB +: OGP_THR_REV_W];
    assign rev_off_o = !thr_cfg_i[OGP_BIT_REV_DIS]
                     && (rev_level_i > rev_thr_w);

    // turn-off conditions beat the threshold; recovers as soon as clear
    assign remote_sel_o = thr_met_o && !fault_off_o
                        && !rev_off_o;
    // disable bit kills the gate but leaves feedback choice alone
    assign gate_act_o = remote_sel_o && !gate_dis_i;
endmodule
`default_nettype wire

// ---- logic/ogp_pgood.sv ----
/*
 * ogp_pgood: fault condition of one power-good pin.
 * Masked flags plus, for the second pin, the additional flag group.
 * Assumes flag inputs are levels, one for fault present.
 */
`default_nettype none
module ogp_pgood
    import ogp_pkg::*;
#(
    parameter bit HAS_EXTRA = 1'b0
) (
    input  wire logic [OGP_PG_NFLAGS-1:0] flag_i,
    input  wire logic [7:0]               mask_i,
    input  wire logic [OGP_XF_NFLAGS-1:0] xflag_i,
    input  wire logic [OGP_XF_NFLAGS-1:0] xact_ignore_i,
    input  wire logic                     xalways_i,
    output logic                          fault_o
);
    wire logic [OGP_PG_NFLAGS-1:0] live_w;
    wire logic [OGP_XF_NFLAGS-1:0] xlive_w;

    // a mask bit of one keeps its flag out
    assign live_w  = flag_i & ~mask_i[OGP_PG_NFLAGS-1:0];
    // extra flags count always, or only when not set to ignore
    assign xlive_w = xflag_i & (xalways_i ? '1 : ~xact_ignore_i);
    assign fault_o = (|live_w) || (HAS_EXTRA && (|xlive_w));
endmodule
`default_nettype wire

// ---- logic/ogp_top.sv ----
/*
 * ogp_top: oring switch gate control and two power-good pins.
 * Holds the five configuration registers behind a simple register port,
 * the gate decision, gate polarity, feedback point select and both
 * open-drain power-good drivers. Assumes all inputs are synchronous to
 * sys_clk_i, sense codes are calibrated, and fault flags come from the
 * fault logic with their configured actions already decoded.
 */
// Operation
// - switch enabled when local-to-bus forward drop exceeds enable threshold
// - threshold field selects 0, -0.5, -1 or -2 percent of nominal
// - fault flag with turn-off action holds switch off while set
// - reverse current above programmed level turns switch off
// - reverse comparator result ignored while its disable bit is set
// - gate disable bit keeps gate off, feedback selection unaffected
// - gate inactive: switch off, regulate from local sense, except under gate disable where remote sense stays selected
// - gate active: switch on, regulate from remote sense
// - once outside bus overvoltage clears, switch back on at once
// - two open-drain power-good pins, pulled low on their fault
// - each power-good pin may respond to the eight listed flags
// - separate mask per pin; masked flag cannot set its fault
// - extra flags set second pin always or unless action is ignore
// - gate output polarity chosen by configuration bit
`default_nettype none
module ogp_top
    import ogp_pkg::*;
#(
    parameter int VW = 12,
    parameter int NF = 8
) (
    input  wire logic                     sys_clk_i,
    input  wire logic                     nrst_i,
    // register port
    input  wire logic [7:0]               reg_addr_i,
    input  wire logic [7:0]               reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    output logic [7:0]                    reg_rdata_o,
    output logic                          reg_rvalid_o,
    // sense and fault inputs
    input  wire logic [VW-1:0]            local_sense_voltage_i,
    input  wire logic [VW-1:0]            bus_sense_voltage_i,
    input  wire logic [VW-1:0]            nominal_voltage_i,
    input  wire logic [OGP_THR_REV_W-1:0] secondary_current_sense_i,
    input  wire logic [NF-1:0]            fault_flag_i,
    input  wire logic [NF-1:0]            fault_act_off_i,
    input  wire logic [OGP_PG_NFLAGS-1:0] pg_flag_i,
    input  wire logic [OGP_XF_NFLAGS-1:0] xflag_i,
    input  wire logic [OGP_XF_NFLAGS-1:0] xact_ignore_i,
    // switch and feedback
    output logic                          oring_switch_gate_o,
    output logic                          remote_sense_sel_o,
    // open-drain power-good pins
    output logic                          first_power_good_o,
    output logic                          first_power_good_oe_o,
    output logic                          second_power_good_o,
    output logic                          second_power_good_oe_o
);
    // configuration registers
    logic [7:0] pg_gate_cfg_r;
    logic [7:0] sw_thr_cfg_r;
    logic [7:0] gate_dis_r;
    logic [7:0] pg1_mask_r;
    logic [7:0] pg2_mask_r;

    // decision wires
    wire logic       thr_met_w;
    wire logic       fault_off_w;
    wire logic       rev_off_w;
    wire logic       gate_act_w;
    wire logic       remote_w;
    wire logic       pg1_fault_w;
    wire logic       pg2_fault_w;
    wire logic [OGP_PG_NFLAGS-1:0] pg_all_w;
    wire logic [OGP_XF_NFLAGS-1:0] xf_all_w;
    wire logic [7:0] status_w;
    wire logic [7:0] rdata_nxt;
    wire logic       gate_pin_nxt;

    // register write decode
    wire logic wr_pgc_w = reg_wr_i && (reg_addr_i == OGP_OFS_PG_GATE_CFG);
    wire logic wr_thr_w = reg_wr_i && (reg_addr_i == OGP_OFS_SW_THR_CFG);
    wire logic wr_dis_w = reg_wr_i && (reg_addr_i == OGP_OFS_GATE_DIS);
    wire logic wr_pm1_w = reg_wr_i && (reg_addr_i == OGP_OFS_PG1_MASK);
    wire logic wr_pm2_w = reg_wr_i && (reg_addr_i == OGP_OFS_PG2_MASK);

    // configuration storage, reset to safe defaults (gate active high)
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pg_gate_cfg_r <= OGP_RST_PG_GATE_CFG;
            sw_thr_cfg_r  <= OGP_RST_SW_THR_CFG;
            gate_dis_r    <= OGP_RST_GATE_DIS;
            pg1_mask_r    <= OGP_RST_PG_MASK;
            pg2_mask_r    <= OGP_RST_PG_MASK;
        end else begin
            if (wr_pgc_w) pg_gate_cfg_r <= reg_wdata_i;
            if (wr_thr_w) sw_thr_cfg_r  <= reg_wdata_i;
            if (wr_dis_w) gate_dis_r    <= reg_wdata_i;
            if (wr_pm1_w) pg1_mask_r    <= reg_wdata_i;
            if (wr_pm2_w) pg2_mask_r    <= reg_wdata_i;
        end
    end

    // gate decision: threshold, fault, reverse current, disable
    ogp_gate_ctrl #(
        .VW (VW),
        .NF (NF)
    ) u_gate (
        .local_sense_voltage_i (local_sense_voltage_i),
        .bus_sense_voltage_i   (bus_sense_voltage_i),
        .nominal_voltage_i     (nominal_voltage_i),
        .fault_flag_i          (fault_flag_i),
        .fault_act_off_i       (fault_act_off_i),
        .rev_level_i           (secondary_current_sense_i),
        .thr_cfg_i             (sw_thr_cfg_r),
        .gate_dis_i            (gate_dis_r[OGP_BIT_GATE_DIS]),
        .thr_met_o             (thr_met_w),
        .fault_off_o           (fault_off_w),
        .rev_off_o             (rev_off_w),
        .gate_act_o            (gate_act_w),
        .remote_sel_o          (remote_w)
    );

    // in-block flags replace their input bits: gate off, switch disabled
    assign pg_all_w = {pg_flag_i[OGP_PG_NFLAGS-1:OGP_PGF_GATE+1],
                       !gate_act_w};
    assign xf_all_w = {xflag_i[OGP_XF_NFLAGS-1:OGP_XF_SW_DIS+1],
                       gate_dis_r[OGP_BIT_GATE_DIS],
                       xflag_i[OGP_XF_SW_DIS-1:0]};

    // first pin: masked flags only
    ogp_pgood #(
        .HAS_EXTRA (1'b0)
    ) u_pg1 (
        .flag_i        (pg_all_w),
        .mask_i        (pg1_mask_r),
        .xflag_i       (xf_all_w),
        .xact_ignore_i (xact_ignore_i),
        .xalways_i     (pg_gate_cfg_r[OGP_BIT_PG2_ALWAYS]),
        .fault_o       (pg1_fault_w)
    );

    // second pin: masked flags plus the additional group
    ogp_pgood #(
        .HAS_EXTRA (1'b1)
    ) u_pg2 (
        .flag_i        (pg_all_w),
        .mask_i        (pg2_mask_r),
        .xflag_i       (xf_all_w),
        .xact_ignore_i (xact_ignore_i),
        .xalways_i     (pg_gate_cfg_r[OGP_BIT_PG2_ALWAYS]),
        .fault_o       (pg2_fault_w)
    );

    // pin level with selectable polarity
    assign gate_pin_nxt = pg_gate_cfg_r[OGP_BIT_GATE_POL]
                        ? gate_act_w : !gate_act_w;

    // status word showing the block's own state
    assign status_w = {2'b00,
                       pg2_fault_w,
                       pg1_fault_w,
                       rev_off_w,
                       fault_off_w,
                       remote_w,
                       gate_act_w};

    // read mux; unmapped addresses read as zero
    assign rdata_nxt =
        (reg_addr_i == OGP_OFS_PG_GATE_CFG) ? pg_gate_cfg_r :
        (reg_addr_i == OGP_OFS_SW_THR_CFG)  ? sw_thr_cfg_r  :
        (reg_addr_i == OGP_OFS_GATE_DIS)    ? gate_dis_r    :
        (reg_addr_i == OGP_OFS_PG1_MASK)    ? pg1_mask_r    :
        (reg_addr_i == OGP_OFS_PG2_MASK)    ? pg2_mask_r    :
        (reg_addr_i == OGP_OFS_STATUS)      ? status_w      :
                                              OGP_RD_UNMAPPED;

    // read answer, one cycle after the strobe
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o  <= OGP_RD_UNMAPPED;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) reg_rdata_o <= rdata_nxt;
        end
    end

    // gate pin and feedback point; registered so outputs are glitch free.
    // reset parks the switch off and feedback on local sense.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            oring_switch_gate_o <= 1'b0;
            remote_sense_sel_o  <= 1'b0;
        end else begin
            oring_switch_gate_o <= gate_pin_nxt;
            remote_sense_sel_o  <= remote_w;
        end
    end

    // open drain: level held low, enable pulls the pin while faulted.
    // reset pulls both pins so the system sees "not good" at power up.
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            first_power_good_o     <= 1'b0;
            second_power_good_o    <= 1'b0;
            first_power_good_oe_o  <= 1'b1;
            second_power_good_oe_o <= 1'b1;
        end else begin
            first_power_good_o     <= 1'b0;
            second_power_good_o    <= 1'b0;
            first_power_good_oe_o  <= pg1_fault_w;
            second_power_good_oe_o <= pg2_fault_w;
        end
    end
endmodule
`default_nettype wire

// ---- dv/ogp_top_assertions.sv ----
/* ogp_top_assertions: port checker for ogp_top, bound below.
   Assumes registers change only through the register port. */
`default_nettype none
module ogp_top_assertions
    import ogp_pkg::*;
#(
    parameter int VW = 12,
    parameter int NF = 8
) (
    input wire logic                     sys_clk_i,
    input wire logic                     nrst_i,
    input wire logic [7:0]               reg_addr_i,
    input wire logic [7:0]               reg_wdata_i,
    input wire logic                     reg_wr_i,
    input wire logic                     reg_rd_i,
    input wire logic                     reg_rvalid_o,
    input wire logic [VW-1:0]            local_sense_voltage_i,
    input wire logic [VW-1:0]            bus_sense_voltage_i,
    input wire logic [OGP_THR_REV_W-1:0] secondary_current_sense_i,
    input wire logic [NF-1:0]            fault_flag_i,
    input wire logic [NF-1:0]            fault_act_off_i,
    input wire logic                     oring_switch_gate_o,
    input wire logic                     remote_sense_sel_o,
    input wire logic                     first_power_good_o,
    input wire logic                     second_power_good_o,
    input wire logic                     second_power_good_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cfg_r;
    logic [7:0] thr_r;
    logic [7:0] dis_r;
    // shadow copies, needed because polarity and disable are not on pins
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_r <= OGP_RST_PG_GATE_CFG;
            thr_r <= OGP_RST_SW_THR_CFG;
            dis_r <= OGP_RST_GATE_DIS;
        end else if (reg_wr_i && reg_addr_i == OGP_OFS_PG_GATE_CFG) begin
            cfg_r <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == OGP_OFS_SW_THR_CFG) begin
            thr_r <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == OGP_OFS_GATE_DIS) begin
            dis_r <= reg_wdata_i;
        end
    end
    // turn-off causes as the block should see them
    wire logic fault_off = |(fault_flag_i & fault_act_off_i);
    wire logic rev_hit = secondary_current_sense_i > thr_r[4:2];
    wire logic off_now = fault_off || (rev_hit && !thr_r[0]);
    wire logic fwd = local_sense_voltage_i > bus_sense_voltage_i;

    property p_read_answer;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        reg_rd_i |=> reg_rvalid_o;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read strobe got no valid");
    property p_fault_off;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        fault_off |=> !remote_sense_sel_o;
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("fault with off action left switch on");
    property p_rev_off;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        rev_hit && !thr_r[0] |=> !remote_sense_sel_o;
    endproperty
    a_rev_off: assert property (p_rev_off)
        else $error("reverse current left switch on");
    property p_enable;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        fwd && !off_now |=> remote_sense_sel_o;
    endproperty
    a_enable: assert property (p_enable)
        else $error("forward drop without turn-off gave no enable");
    property p_gate_pin;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        oring_switch_gate_o ==
            ($past(cfg_r[1]) ~^ (remote_sense_sel_o && !$past(dis_r[0])));
    endproperty
    a_gate_pin: assert property (p_gate_pin)
        else $error("gate pin disagrees with decision");
    property p_pg2_swdis;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        dis_r[0] && cfg_r[3] |=> second_power_good_oe_o;
    endproperty
    a_pg2_swdis: assert property (p_pg2_swdis)
        else $error("switch disable did not pull second pin");
    property p_od_low;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        !first_power_good_o && !second_power_good_o;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("power-good pin driven high");
    property p_dis_keeps_sel;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        dis_r[0] && fwd && !off_now |=> remote_sense_sel_o;
    endproperty
    a_dis_keeps_sel: assert property (p_dis_keeps_sel)
        else $error("gate disable moved feedback point");
endmodule
bind ogp_top ogp_top_assertions #(.VW(VW), .NF(NF)) ogp_top_assertions_i (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rvalid_o(reg_rvalid_o),
    .local_sense_voltage_i(local_sense_voltage_i),
    .bus_sense_voltage_i(bus_sense_voltage_i),
    .secondary_current_sense_i(secondary_current_sense_i),
    .fault_flag_i(fault_flag_i), .fault_act_off_i(fault_act_off_i),
    .oring_switch_gate_o(oring_switch_gate_o),
    .remote_sense_sel_o(remote_sense_sel_o),
    .first_power_good_o(first_power_good_o),
    .second_power_good_o(second_power_good_o),
    .second_power_good_oe_o(second_power_good_oe_o));
`default_nettype wire

// ---- dv/ogp_partner.sv ----
/* ogp_partner: external switch driver and pulled-up power-good lines.
   Assumes the driver is strapped to the same polarity as the gate pin. */
`default_nettype none
module ogp_partner (
    input  wire logic gate_i,
    input  wire logic pol_i,
    input  wire logic pg1_i,
    input  wire logic pg1_oe_i,
    input  wire logic pg2_i,
    input  wire logic pg2_oe_i,
    output logic      sw_on_o,
    output logic      pg1_line_o,
    output logic      pg2_line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // driver conducts only at the strapped active level
    assign sw_on_o = gate_i ~^ pol_i;
    // released lines float up through the pull-up resistors
    assign pg1_line_o = pg1_oe_i ? pg1_i : 1'b1;
    assign pg2_line_o = pg2_oe_i ? pg2_i : 1'b1;
endmodule
`default_nettype wire

// ---- dv/ogp_top_test.sv ----
/* ogp_top_test: directed register and gate tests for ogp_top.
   Assumes ogp_partner and the bound checker are compiled alongside. */
`default_nettype none
module ogp_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import ogp_pkg::*;
    logic        clk, nrst, wr, rd, rvalid, gate, rsel, pol;
    logic        pg1, pg1_oe, pg2, pg2_oe, sw_on, pg1_ln, pg2_ln;
    logic [7:0]  addr, wdata, rdata, pgf, ff, act;
    logic [11:0] loc, bus, nom;
    logic [2:0]  rev;
    logic [4:0]  xf, xig;
    int          error_cnt, checks_done;
    int          lim[4] = '{0, 5, 10, 20};

    ogp_top #(.VW(12), .NF(8)) ogp_top_i (
        .sys_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .local_sense_voltage_i(loc), .bus_sense_voltage_i(bus),
        .nominal_voltage_i(nom), .secondary_current_sense_i(rev),
        .fault_flag_i(ff), .fault_act_off_i(act), .pg_flag_i(pgf),
        .xflag_i(xf), .xact_ignore_i(xig), .oring_switch_gate_o(gate),
        .remote_sense_sel_o(rsel), .first_power_good_o(pg1),
        .first_power_good_oe_o(pg1_oe), .second_power_good_o(pg2),
        .second_power_good_oe_o(pg2_oe));
    ogp_partner ogp_partner_i (.gate_i(gate), .pol_i(pol), .pg1_i(pg1),
        .pg1_oe_i(pg1_oe), .pg2_i(pg2), .pg2_oe_i(pg2_oe),
        .sw_on_o(sw_on), .pg1_line_o(pg1_ln), .pg2_line_o(pg2_ln));

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk("rvalid", 8'h01, 8'(rvalid));
        chk("rdata", e, rdata);
    endtask
    // two falling edges: register lands, then outputs follow
    task automatic settle();
        repeat (2) @(negedge clk);
    endtask
    task automatic chk_on(input logic r, input logic s);
        chk("remote_sel", 8'(r), 8'(rsel));
        chk("switch_on", 8'(s), 8'(sw_on));
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // far longer than the roughly 90 cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end

    initial begin
        {nrst, wr, rd, addr, wdata, rev, ff, act, pgf, xf, xig} = '0;
        pol = 1'b1;
        loc = 12'd1000; // sense codes taken as calibrated
        bus = 12'd1000;
        nom = 12'd1000;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        rd_reg(OGP_OFS_PG_GATE_CFG, OGP_RST_PG_GATE_CFG);
        rd_reg(OGP_OFS_SW_THR_CFG, OGP_RST_SW_THR_CFG);
        rd_reg(OGP_OFS_GATE_DIS, OGP_RST_GATE_DIS);
        rd_reg(OGP_OFS_PG1_MASK, OGP_RST_PG_MASK);
        rd_reg(OGP_OFS_PG2_MASK, OGP_RST_PG_MASK);
        wr_reg(8'h40, 8'h5A);
        rd_reg(8'h40, OGP_RD_UNMAPPED);
        $display("test registers done");
        // each code at its boundary: equal drop refused, one more taken
        for (int c = 0; c < 4; c++) begin
            wr_reg(OGP_OFS_SW_THR_CFG, 8'(c << 5));
            bus = 12'(1000 + lim[c]);
            settle();
            chk_on(1'b0, 1'b0);
            bus = 12'(999 + lim[c]);
            settle();
            chk_on(1'b1, 1'b1);
        end
        $display("test thresholds done");
        ff = 8'h01; // line sense flag set
        act = 8'h01; // its action turns the switch off
        settle();
        chk_on(1'b0, 1'b0);
        act = 8'h00; // action left to shutdown and restart
        settle();
        chk_on(1'b1, 1'b1);
        ff = 8'h00;
        wr_reg(OGP_OFS_SW_THR_CFG, 8'h6C);
        rev = 3'd3;
        settle();
        chk_on(1'b1, 1'b1);
        rev = 3'd4;
        settle();
        chk_on(1'b0, 1'b0);
        wr_reg(OGP_OFS_SW_THR_CFG, 8'h6D);
        settle();
        chk_on(1'b1, 1'b1);
        rev = 3'd0;
        bus = 12'd990; // forward drop, so disable must keep remote
        $display("test turn-off done");
        wr_reg(OGP_OFS_GATE_DIS, 8'h01);
        settle();
        chk_on(1'b1, 1'b0);
        chk("pg2_line", 8'h00, 8'(pg2_ln));
        xig = 5'b00010;
        settle();
        chk("pg2_line", 8'h01, 8'(pg2_ln));
        wr_reg(OGP_OFS_PG_GATE_CFG, 8'h0A);
        settle();
        chk("pg2_line", 8'h00, 8'(pg2_ln));
        wr_reg(OGP_OFS_GATE_DIS, 8'h00);
        wr_reg(OGP_OFS_PG_GATE_CFG, 8'h02);
        $display("test disable done");
        pgf = 8'h80;
        settle();
        chk("pg1_line", 8'h01, 8'(pg1_ln));
        wr_reg(OGP_OFS_PG1_MASK, 8'h7F);
        settle();
        chk("pg1_line", 8'h00, 8'(pg1_ln));
        chk("pg2_line", 8'h01, 8'(pg2_ln));
        pgf = 8'h00;
        wr_reg(OGP_OFS_PG2_MASK, 8'hFE);
        bus = 12'd1100;
        settle();
        chk_on(1'b0, 1'b0);
        chk("pg2_line", 8'h00, 8'(pg2_ln));
        bus = 12'd990;
        settle();
        chk_on(1'b1, 1'b1);
        chk("pg2_line", 8'h01, 8'(pg2_ln));
        $display("test power-good done");
        wr_reg(OGP_OFS_PG_GATE_CFG, 8'h00);
        pol = 1'b0;
        settle();
        chk("gate_pin", 8'h00, 8'(gate));
        chk_on(1'b1, 1'b1);
        rd_reg(OGP_OFS_STATUS, 8'h03); // gate and remote bits
        $display("test polarity done");
        nrst = 1'b0; // mid-run reset pulls both pins
        settle();
        chk("pg1_line", 8'h00, 8'(pg1_ln));
        chk("remote_sel", 8'h00, 8'(rsel));
        nrst = 1'b1;
        rd_reg(OGP_OFS_PG_GATE_CFG, OGP_RST_PG_GATE_CFG);
        $display("test reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
